/* cps_regs.vh */
`ifndef CPS_REGS_VH
`define CPS_REGS_VH
// ==========================================================
// register byte offsets
`define CPS_OFF_CTRL 12'h000
`define CPS_OFF_STAT 12'h004
`define CPS_OFF_IN 12'h008
`define CPS_OFF_OUT 12'h00c
`define CPS_OFF_PEER 12'h010
// ==========================================================
// ctrl fields
`define CPS_CTRL_START 0
`define CPS_CTRL_STOP 1
`define CPS_CTRL_PREOP 2
`define CPS_CTRL_INPOL_LSB 8
`define CPS_CTRL_OUTPOL_LSB 16
`define CPS_CTRL_RST 32'h00000000
// ==========================================================
// status fields
`define CPS_ST_ID_LSB 0
`define CPS_ST_RATE_LSB 8
`define CPS_ST_PAIR 11
`define CPS_ST_FWUPD 12
`define CPS_ST_BAD 13
`define CPS_ST_NMT_LSB 16
// ==========================================================
// network states
`define CPS_NMT_INIT 2'h0
`define CPS_NMT_PREOP 2'h1
`define CPS_NMT_OPER 2'h2
`define CPS_NMT_STOP 2'h3
// ==========================================================
// limits and timing
`define CPS_ID_MAX 7'h63
`define CPS_CLK_HZ 50000000
`define CPS_BLINK_MS 200
`define CPS_FLASH_MS 1000
`define CPS_BLINK_CYC (`CPS_CLK_HZ / 1000 * `CPS_BLINK_MS)
`define CPS_FLASH_CYC (`CPS_CLK_HZ / 1000 * `CPS_FLASH_MS)
`define CPS_SETTLE 4'hf
`endif

/* cps_switch_pair_io.v */
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "cps_regs.vh"
module cps_switch_pair_io #(
  parameter BLINK_CYC = `CPS_BLINK_CYC,
  parameter FLASH_CYC = `CPS_FLASH_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // rotary switches
  input wire [3:0] swTens,
  input wire [3:0] swUnits,
  input wire [3:0] swRate,
  // channels
  input wire [7:0] inputChannel,
  output reg [7:0] outputChannel,
  // peer link from the can controller
  input wire [7:0] peerInputs,
  output reg [7:0] localInputs,
  // decoded configuration
  output reg [6:0] stationNumber,
  output reg [2:0] bitRateSel,
  output reg [9:0] bitRateKbps,
  output reg pairMode,
  output reg fwUpdate,
  output reg netEnable,
  output reg runLed,
  // axi4-lite slave
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // ========================================================
  // helpers
  function [9:0] rateKbps;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: rateKbps = 10'h00a;
        3'h1: rateKbps = 10'h014;
        3'h2: rateKbps = 10'h032;
        3'h3: rateKbps = 10'h07d;
        3'h4: rateKbps = 10'h0fa;
        3'h5: rateKbps = 10'h1f4;
        3'h6: rateKbps = 10'h320;
        default: rateKbps = 10'h3e8;
      endcase
    end
  endfunction
  // ========================================================
  // synchronisers for all pin inputs
  reg [11:0] swMeta_r, swSync_r;
  reg [7:0] inMeta_r, inSync_r;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      swMeta_r <= 12'h000;
      swSync_r <= 12'h000;
      inMeta_r <= 8'h00;
      inSync_r <= 8'h00;
    end else begin
      swMeta_r <= {swTens, swUnits, swRate};
      swSync_r <= swMeta_r;
      inMeta_r <= inputChannel;
      inSync_r <= inMeta_r;
    end
  end
  // ========================================================
  // one-shot capture of switches after reset settles
  reg [3:0] settle_r;
  reg captured_r;
  wire [3:0] tSync = swSync_r[11:8];
  wire [3:0] uSync = swSync_r[7:4];
  wire [3:0] rSync = swSync_r[3:0];
  // multiply by ten as 8x+2x, kept to 7 bits
  wire [6:0] idCalc = {tSync[3:0], 3'h0} + {2'h0, tSync, 1'h0}
                      + {3'h0, uSync};
  wire digitBad = (tSync > 4'h9) || (uSync > 4'h9);
  reg badSw_r;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      settle_r <= 4'h0;
      captured_r <= 1'b0;
      stationNumber <= 7'h00;
      bitRateSel <= 3'h0;
      bitRateKbps <= 10'h000;
      pairMode <= 1'b0;
      fwUpdate <= 1'b0;
      badSw_r <= 1'b0;
    end else if (!captured_r) begin
      // wait for synchroniser to fill before the single capture
      if (settle_r != `CPS_SETTLE) begin
        settle_r <= settle_r + 4'h1;
      end else begin
        captured_r <= 1'b1;
        stationNumber <= idCalc;
        bitRateSel <= rSync[2:0];
        bitRateKbps <= rateKbps(rSync[2:0]);
        pairMode <= rSync[3];
        fwUpdate <= !digitBad && (idCalc == 7'h00);
        badSw_r <= digitBad || (idCalc > `CPS_ID_MAX);
      end
    end
  end
  // ========================================================
  // bus-visible control
  reg [31:0] ctrl_r;
  reg cmdStart_r, cmdStop_r, cmdPreop_r;
  // ========================================================
  // network state machine
  reg [1:0] nmt_r, nmt_nxt;
  always @* begin
    nmt_nxt = nmt_r;
    case (nmt_r)
      `CPS_NMT_INIT: begin
        if (captured_r && !badSw_r && !fwUpdate)
          nmt_nxt = pairMode ? `CPS_NMT_OPER : `CPS_NMT_PREOP;
      end
      `CPS_NMT_PREOP, `CPS_NMT_OPER, `CPS_NMT_STOP: begin
        if (cmdStop_r)
          nmt_nxt = `CPS_NMT_STOP;
        else if (cmdStart_r)
          nmt_nxt = `CPS_NMT_OPER;
        else if (cmdPreop_r)
          nmt_nxt = `CPS_NMT_PREOP;
      end
      default: nmt_nxt = `CPS_NMT_INIT;
    endcase
  end
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      nmt_r <= `CPS_NMT_INIT;
    else
      nmt_r <= nmt_nxt;
  end
  // ========================================================
  // channel data paths with polarity; peer inputs mirror in pair mode
  reg [7:0] hostOut_r;
  wire [7:0] inPol = ctrl_r[`CPS_CTRL_INPOL_LSB +: 8];
  wire [7:0] outPol = ctrl_r[`CPS_CTRL_OUTPOL_LSB +: 8];
  wire [7:0] logicOut = pairMode ? peerInputs : hostOut_r;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      localInputs <= 8'h00;
      outputChannel <= 8'h00;
      netEnable <= 1'b0;
    end else begin
      localInputs <= inSync_r ^ inPol;
      // outputs held off unless operational
      outputChannel <= (nmt_r == `CPS_NMT_OPER) ?
                       (logicOut ^ outPol) : 8'h00;
      netEnable <= (nmt_r != `CPS_NMT_INIT);
    end
  end
  // ========================================================
  // run indicator timing
  reg [31:0] blinkCnt_r, flashCnt_r;
  reg blink_r, flash_r;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      blinkCnt_r <= 32'h0;
      flashCnt_r <= 32'h0;
      blink_r <= 1'b0;
      flash_r <= 1'b0;
      runLed <= 1'b0;
    end else begin
      blinkCnt_r <= (blinkCnt_r >= BLINK_CYC - 1) ? 32'h0 :
                    blinkCnt_r + 32'h1;
      if (blinkCnt_r >= BLINK_CYC - 1)
        blink_r <= !blink_r;
      flashCnt_r <= (flashCnt_r >= FLASH_CYC - 1) ? 32'h0 :
                    flashCnt_r + 32'h1;
      // single flash: on for one blink period per flash cycle
      flash_r <= (flashCnt_r < BLINK_CYC);
      case (nmt_r)
        `CPS_NMT_STOP: runLed <= flash_r;
        `CPS_NMT_PREOP: runLed <= blink_r;
        `CPS_NMT_OPER: runLed <= 1'b1;
        default: runLed <= 1'b0;
      endcase
    end
  end
  // ========================================================
  // axi4-lite write: take both, answer one cycle later
  reg awHave_r, wHave_r;
  reg [11:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  assign s_axi_awready = !awHave_r && !s_axi_bvalid;
  assign s_axi_wready = !wHave_r && !s_axi_bvalid;
  integer i;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 12'h000;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_r <= `CPS_CTRL_RST;
      hostOut_r <= 8'h00;
      cmdStart_r <= 1'b0;
      cmdStop_r <= 1'b0;
      cmdPreop_r <= 1'b0;
    end else begin
      cmdStart_r <= 1'b0;
      cmdStop_r <= 1'b0;
      cmdPreop_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (awHave_r && wHave_r) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (awAddr_r >> 2)
          `CPS_OFF_CTRL >> 2: begin
            for (i = 0; i < 4; i = i + 1)
              if (wStrb_r[i])
                ctrl_r[i*8 +: 8] <= wData_r[i*8 +: 8];
            // command bits act once and are not stored
            if (wStrb_r[0]) begin
              cmdStart_r <= wData_r[`CPS_CTRL_START];
              cmdStop_r <= wData_r[`CPS_CTRL_STOP];
              cmdPreop_r <= wData_r[`CPS_CTRL_PREOP];
              ctrl_r[2:0] <= 3'h0;
            end
          end
          `CPS_OFF_OUT >> 2: begin
            if (wStrb_r[0])
              hostOut_r <= wData_r[7:0];
          end
          `CPS_OFF_STAT >> 2, `CPS_OFF_IN >> 2, `CPS_OFF_PEER >> 2: ;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ========================================================
  // axi4-lite read: data one cycle after address taken
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr >> 2)
        `CPS_OFF_CTRL >> 2: s_axi_rdata <= ctrl_r;
        `CPS_OFF_STAT >> 2: s_axi_rdata <= {14'h0, nmt_r, 2'h0,
          badSw_r, fwUpdate, pairMode, bitRateSel, 1'b0, stationNumber};
        `CPS_OFF_IN >> 2: s_axi_rdata <= {24'h0, localInputs};
        `CPS_OFF_OUT >> 2: s_axi_rdata <= {24'h0, hostOut_r};
        `CPS_OFF_PEER >> 2: s_axi_rdata <= {24'h0, peerInputs};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* cps_switch_pair_io_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker for the switch and pair io block
module cps_switch_pair_io_checker #(
  parameter BLINK_CYC = 4,
  parameter FLASH_CYC = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // decoded configuration
  input wire logic [6:0] stationNumber,
  input wire logic [2:0] bitRateSel,
  input wire logic [9:0] bitRateKbps,
  input wire logic pairMode,
  input wire logic fwUpdate,
  input wire logic netEnable,
  input wire logic runLed,
  input wire logic [7:0] outputChannel,
  // read channel
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // kbit/s per rate select, lowest select in the low slice
  localparam logic [79:0] KB = {10'h3e8, 10'h320, 10'h1f4, 10'h0fa,
    10'h07d, 10'h032, 10'h014, 10'h00a};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_rate_map: assert property (netEnable |->
    bitRateKbps == KB[10*bitRateSel +: 10]) else $error("bad rate");
  chk_id_range: assert property (netEnable |->
    stationNumber != 7'h00 && stationNumber <= 7'h63) else $error("bad id");
  chk_fw_quiet: assert property (fwUpdate |-> !netEnable)
    else $error("joined while in update");
  // config may move only at the capture edge, never while joined
  chk_cfg_hold: assert property (netEnable && $past(netEnable) |->
    $stable(stationNumber) && $stable(bitRateSel) && $stable(pairMode))
    else $error("config moved");
  chk_led_off: assert property (!netEnable |-> !runLed)
    else $error("led lit in init");
  chk_pair_oper: assert property ($rose(netEnable) && pairMode |=>
    runLed) else $error("pair mode not operational");
  chk_out_idle: assert property (!netEnable |->
    outputChannel == 8'h00) else $error("outputs driven in init");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
endmodule
bind cps_switch_pair_io cps_switch_pair_io_checker #(
  .BLINK_CYC(BLINK_CYC), .FLASH_CYC(FLASH_CYC)
) chk (.clk_sys(clk_sys), .arst_n(arst_n), .stationNumber(stationNumber),
  .bitRateSel(bitRateSel), .bitRateKbps(bitRateKbps), .pairMode(pairMode),
  .fwUpdate(fwUpdate), .netEnable(netEnable), .runLed(runLed),
  .outputChannel(outputChannel), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

/* cps_peer_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// partner io module across the can link
module cps_peer_model #(
  parameter OWN_ID = 7'h04 // one above the odd local station
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // partner pins and link
  input wire logic [7:0] peerPins,
  input wire logic [7:0] fromDut,
  output var logic [7:0] toDut,
  output var logic [7:0] peerOut
);
  // one link hop of delay each way; the real bus is slower still
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      toDut <= 8'h00;
      peerOut <= 8'h00;
    end else begin
      toDut <= peerPins;
      peerOut <= fromDut;
    end
  end
endmodule
`default_nettype wire

/* cps_switch_pair_io_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cps_regs.vh"
// ==========================================================
// bench
module cps_switch_pair_io_test;
  localparam logic [79:0] KB = {10'h3e8, 10'h320, 10'h1f4, 10'h0fa,
    10'h07d, 10'h032, 10'h014, 10'h00a};
  logic clk_sys = 1'b0, arst_n = 1'b0, awV = 1'b0, wV = 1'b0, bR = 1'b0;
  logic arV = 1'b0, rR = 1'b0;
  logic [3:0] swT = 4'h0, swU = 4'h0, swR = 4'h0;
  logic [11:0] awA = 12'h000, arA = 12'h000;
  logic [31:0] wD = 32'h0, rv;
  logic [7:0] inCh = 8'h00, pPins = 8'h00;
  logic [1:0] rs, bs;
  wire awRd, wRd, bV, arRd, rV, pm, fw, ne, led;
  wire [1:0] bRsp, rRsp;
  wire [31:0] rD;
  wire [7:0] outCh, locIn, peerIn, pOut;
  wire [6:0] stn;
  wire [2:0] sel;
  wire [9:0] kb;
  integer miscompares = 0, checks = 0, cyc = 0, i, n;
  cps_switch_pair_io #(.BLINK_CYC(4), .FLASH_CYC(16)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .swTens(swT), .swUnits(swU),
    .swRate(swR), .inputChannel(inCh), .outputChannel(outCh),
    .peerInputs(peerIn), .localInputs(locIn), .stationNumber(stn),
    .bitRateSel(sel), .bitRateKbps(kb), .pairMode(pm), .fwUpdate(fw),
    .netEnable(ne), .runLed(led), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
    .s_axi_awready(awRd), .s_axi_wdata(wD), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wV), .s_axi_wready(wRd), .s_axi_bresp(bRsp),
    .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA),
    .s_axi_arvalid(arV), .s_axi_arready(arRd), .s_axi_rdata(rD),
    .s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rR));
  cps_peer_model peer (.clk_sys(clk_sys), .arst_n(arst_n),
    .peerPins(pPins), .fromDut(locIn), .toDut(peerIn), .peerOut(pOut));
  always #10 clk_sys = ~clk_sys;
  // a hung handshake ends the run here rather than never
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // switches only count at capture, so each setting needs a reset
  task boot(input logic [3:0] t, input logic [3:0] u, input logic [3:0] r);
    arst_n <= 1'b0;
    swT <= t;
    swU <= u;
    swR <= r;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (22) @(posedge clk_sys);
  endtask
  // handshakes are sampled mid-cycle, acted on at the next edge
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    bR <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk_sys);
      ta = awV && awRd;
      tw = wV && wRd;
      tb = bV && bR;
      bs = bRsp;
      @(posedge clk_sys);
      if (ta) awV <= 1'b0;
      if (tw) wV <= 1'b0;
    end
    bR <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [11:0] a);
    logic ta, tv, tr;
    arA <= a;
    arV <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk_sys);
      ta = arV && arRd;
      tv = rV;
      tr = rV && rR;
      rv = rD;
      rs = rRsp;
      @(posedge clk_sys);
      if (ta) arV <= 1'b0;
      if (tv) rR <= 1'b1;
    end
    rR <= 1'b0;
    @(posedge clk_sys);
  endtask
  // lit cycles in a 16-cycle window, sampled away from the launch edge
  task led_count(output integer c);
    c = 0;
    repeat (16) begin
      @(negedge clk_sys);
      c = c + led;
    end
    @(posedge clk_sys);
  endtask
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      boot(4'(i % 10), 4'h9, 4'(i));
      cmp(stn, i % 10 * 10 + 9);
      cmp(sel, i % 8);
      cmp(kb, KB[10*(i%8) +: 10]);
      cmp(pm, i / 8);
      cmp({ne, fw}, 2'h2);
      rd(`CPS_OFF_STAT);
      cmp(rv[17:16], i < 8 ? 1 : 2);
    end
    $display("switch decode test done");
    boot(4'h0, 4'h0, 4'h3);
    cmp({ne, fw}, 2'h1);
    boot(4'ha, 4'h2, 4'h3);
    cmp({ne, fw}, 2'h0);
    $display("update and bad digit test done");
    boot(4'h1, 4'h2, 4'h5);
    led_count(n);
    cmp(n, 8);
    inCh <= 8'h3c;
    wr(`CPS_OFF_OUT, 32'h000000a5);
    cmp(bs, 2'h0);
    cmp(outCh, 8'h00);
    wr(`CPS_OFF_CTRL, 32'h00ff0f01);
    repeat (2) @(posedge clk_sys);
    cmp(outCh, 8'h5a);
    led_count(n);
    cmp(n, 16);
    rd(`CPS_OFF_IN);
    cmp(rv, 32'h00000033);
    rd(12'h100);
    cmp(rs, 2'h2);
    cmp(rv, 32'h0);
    wr(12'h100, 32'h00000001);
    cmp(bs, 2'h2);
    wr(`CPS_OFF_CTRL, 32'h00000002);
    rd(`CPS_OFF_STAT);
    cmp(rv[17:16], 2'h3);
    cmp(outCh, 8'h00);
    led_count(n);
    cmp(n, 4);
    wr(`CPS_OFF_CTRL, 32'h00000004);
    rd(`CPS_OFF_STAT);
    cmp(rv[17:16], 2'h1);
    wr(`CPS_OFF_CTRL, 32'h00000007);
    rd(`CPS_OFF_STAT);
    cmp(rv[17:16], 2'h3);
    $display("normal mode test done");
    boot(4'h0, 4'h3, 4'h8);
    pPins <= 8'h81;
    inCh <= 8'h42;
    swT <= 4'h9;
    repeat (6) @(posedge clk_sys);
    cmp(outCh, 8'h81);
    cmp(pOut, 8'h42);
    cmp(stn, 7'h03);
    cmp(led, 1'b1);
    $display("pair mode test done");
    close_out;
  end
endmodule
`default_nettype wire
